// ### wdlpm_defs.svh
// Offsets, field positions, reset values and timing counts
`ifndef WDLPM_DEFS_SVH
`define WDLPM_DEFS_SVH
`define WDLPM_OFF_KEY      4'h0
`define WDLPM_OFF_CTRL     4'h1
`define WDLPM_OFF_LPCTRL   4'h2
`define WDLPM_OFF_WAKESEL  4'h3
`define WDLPM_OFF_STATUS   4'h4
`define WDLPM_OFF_MASK     4'h5
`define WDLPM_OFF_COUNT    4'h6
`define WDLPM_KEY_FIRST    8'h55
`define WDLPM_KEY_SECOND   8'haa
`define WDLPM_CTRL_DIS     0
`define WDLPM_CTRL_WATCHDOG_RESET_OUT   1
`define WDLPM_CTRL_RST     32'h0000_0000
`define WDLPM_LP_MODE_LO   0
`define WDLPM_LP_ENTER     2
`define WDLPM_LP_QUAL_LO   8
`define WDLPM_LPCTRL_RST   32'h0000_0000
`define WDLPM_PULSE_CYC    512
`define WDLPM_ST_OVF       0
`define WDLPM_ST_WAKE      1
`define WDLPM_ST_KEYBAD    2
`endif

// ### wdlpm_pkg.sv
// Types shared by the watchdog and low-power block
package wdlpm_pkg;
    typedef enum logic [1:0] {
        WDLPM_RUN     = 2'b00,
        WDLPM_IDLE    = 2'b01,
        WDLPM_STANDBY = 2'b10,
        WDLPM_HALT    = 2'b11
    } wdlpm_state_type;
    typedef struct packed {
        logic       dis;
        logic       rst_en;
        logic [1:0] mode;
        logic [5:0] qual;
    } wdlpm_cfg_type;
endpackage

// ### wdlpm_qual.sv
// Wake-pin synchroniser and qualification filter
module wdlpm_qual
    import wdlpm_pkg::*;
#(
    parameter int PINS = 32,
    parameter int QW   = 6
) (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic [PINS-1:0] pins_n,
    input  wire logic [PINS-1:0] sel,
    input  wire logic [QW-1:0]   qual,
    output logic                 wake
);
    logic [PINS-1:0] s1_reg;
    logic [PINS-1:0] s2_reg;
    logic [PINS-1:0] s3_reg;
    logic [QW:0]     cnt_reg;
    logic            low;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_reg <= '1;
            s2_reg <= '1;
            s3_reg <= '1;
        end else begin
            s1_reg <= pins_n;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Selected pin low with second and third stage agreeing
    assign low = |(~s2_reg & ~s3_reg & sel);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
            wake    <= 1'b0;
        end else if (!low) begin
            cnt_reg <= '0;
            wake    <= 1'b0;
        end else if (cnt_reg < {1'b0, qual}) begin
            cnt_reg <= cnt_reg + 1'b1;
            wake    <= 1'b0;
        end else begin
            wake <= 1'b1;
        end
    end
endmodule

// ### wdlpm_top.sv
// Watchdog counter and low-power mode controller
`include "wdlpm_defs.svh"
module wdlpm_top
    import wdlpm_pkg::*;
#(
    parameter int WD_W    = 8,
    parameter int PINS    = 32,
    parameter int PRESCL  = 512
) (
    input  wire logic            MCLK,
    input  wire logic            RST,
    input  wire logic [3:0]      AVS_ADDRESS,
    input  wire logic            AVS_READ,
    input  wire logic            AVS_WRITE,
    input  wire logic [31:0]     AVS_WRITEDATA,
    input  wire logic [3:0]      AVS_BYTEENABLE,
    output logic [31:0]          AVS_READDATA,
    output logic                 AVS_WAITREQUEST,
    input  wire logic            EXT_RESET_N,
    input  wire logic [PINS-1:0] PORTA_N,
    input  wire logic            DEBUG_WAKE_N,
    input  wire logic            LIMP_ACTIVE,
    input  wire logic            WATCHDOG_CLOCK_OK,
    input  wire logic            CPU_INT_N,
    input  wire logic            IDLE_REQ,
    output logic                 WATCHDOG_RESET_OUT_N,
    output logic                 WATCHDOG_WAKE_INT_N,
    output logic                 EXPANDER_INT,
    output logic                 CPU_CLOCK_IN_EN,
    output logic                 SYSTEM_CLOCK_OUT_EN,
    output logic                 OSC_PLL_EN,
    output logic                 PIN_HOLD,
    output logic [1:0]           LP_STATE,
    output logic                 IRQ
);
    localparam int PW = $clog2(`WDLPM_PULSE_CYC + 1);

    logic [WD_W-1:0]      cnt_reg;
    logic [9:0]           pre_reg;
    logic                 tick;
    logic                 key_half_reg;
    logic                 key_clr;
    logic                 key_bad;
    logic [PW-1:0]        pulse_reg;
    logic                 pulse_act;
    logic                 ovf;
    logic [31:0]          ctrl_reg;
    logic [31:0]          lpctrl_reg;
    logic [PINS-1:0]      wakesel_reg;
    logic [2:0]           status_reg;
    logic [2:0]           mask_reg;
    logic [2:0]           ev;
    logic [31:0]          rdata_next;
    logic                 wr;
    logic                 rd;
    logic                 ack_reg;
    logic                 pin_wake;
    logic [2:0]           xr_reg;
    logic [2:0]           lp_reg;
    logic [2:0]           dbg_reg;
    logic [2:0]           ci_reg;
    logic                 xr_low;
    logic                 limp_s;
    logic                 wdck_s;
    logic                 cpu_int;
    logic                 dbg_low;
    logic                 enter_req;
    wdlpm_state_type      st_reg;
    wdlpm_state_type      st_next;
    wdlpm_cfg_type        cfg;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign cfg.dis    = ctrl_reg[`WDLPM_CTRL_DIS];
    assign cfg.rst_en = ctrl_reg[`WDLPM_CTRL_WATCHDOG_RESET_OUT];
    assign cfg.mode   = lpctrl_reg[`WDLPM_LP_MODE_LO +: 2];
    assign cfg.qual   = lpctrl_reg[`WDLPM_LP_QUAL_LO +: 6];

    // Bus slave: one wait cycle then acknowledge
    assign wr = AVS_WRITE && ack_reg;
    assign rd = AVS_READ && !ack_reg;
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_reg;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (AVS_READ || AVS_WRITE) && !ack_reg;
        end
    end

    // Asynchronous inputs: three flops, second and third agree
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            xr_reg  <= 3'b111;
            lp_reg  <= 3'b000;
            dbg_reg <= 3'b111;
            ci_reg  <= 3'b111;
        end else begin
            xr_reg  <= {xr_reg[1:0], EXT_RESET_N};
            lp_reg  <= {lp_reg[1:0], LIMP_ACTIVE};
            dbg_reg <= {dbg_reg[1:0], DEBUG_WAKE_N};
            ci_reg  <= {ci_reg[1:0], CPU_INT_N};
        end
    end

    assign xr_low  = !xr_reg[1] && !xr_reg[2];
    assign limp_s  = lp_reg[1] && lp_reg[2];
    assign dbg_low = !dbg_reg[1] && !dbg_reg[2];
    assign cpu_int = !ci_reg[1] && !ci_reg[2];

    logic [2:0] wk_reg;
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            wk_reg <= 3'b000;
        end else begin
            wk_reg <= {wk_reg[1:0], WATCHDOG_CLOCK_OK};
        end
    end
    assign wdck_s = wk_reg[1] && wk_reg[2];

    // Watchdog clock prescaler
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            pre_reg <= '0;
        end else if (pre_reg == 10'(PRESCL - 1)) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + 1'b1;
        end
    end
    assign tick = (pre_reg == 10'(PRESCL - 1));

    // Key sequence detection
    assign key_clr = wr && AVS_ADDRESS == `WDLPM_OFF_KEY && AVS_BYTEENABLE[0]
                     && key_half_reg
                     && AVS_WRITEDATA[7:0] == `WDLPM_KEY_SECOND;
    assign key_bad = wr && AVS_ADDRESS == `WDLPM_OFF_KEY && AVS_BYTEENABLE[0]
                     && !key_clr
                     && AVS_WRITEDATA[7:0] != `WDLPM_KEY_FIRST;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            key_half_reg <= 1'b0;
        end else if (wr && AVS_ADDRESS == `WDLPM_OFF_KEY
                     && AVS_BYTEENABLE[0]) begin
            // Any unexpected value falls back to waiting for the first
            key_half_reg <= (AVS_WRITEDATA[7:0] == `WDLPM_KEY_FIRST);
        end
    end

    // Watchdog counter
    assign ovf = tick && !cfg.dis && !limp_s && !pulse_act
                 && cnt_reg == {WD_W{1'b1}};

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            cnt_reg <= '0;
        end else if (key_clr || cfg.dis) begin
            cnt_reg <= '0;
        end else if (tick && !limp_s && !pulse_act) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    // Overflow pulse, 512 oscillator clocks
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            pulse_reg <= '0;
        end else if (ovf) begin
            pulse_reg <= PW'(`WDLPM_PULSE_CYC);
        end else if (pulse_reg != '0) begin
            pulse_reg <= pulse_reg - 1'b1;
        end
    end
    assign pulse_act = (pulse_reg != '0);

    // Reset in reset mode, and for one cycle from halt as the pulse wakes to run; otherwise interrupt form
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            WATCHDOG_RESET_OUT_N <= 1'b1;
            WATCHDOG_WAKE_INT_N  <= 1'b1;
            EXPANDER_INT         <= 1'b0;
        end else begin
            WATCHDOG_RESET_OUT_N <= !(pulse_act
                && (cfg.rst_en || st_reg == WDLPM_HALT));
            WATCHDOG_WAKE_INT_N  <= !(pulse_act && !cfg.rst_en
                && st_reg != WDLPM_HALT);
            EXPANDER_INT <= pulse_act && !cfg.rst_en
                && st_reg != WDLPM_HALT
                && st_reg != WDLPM_STANDBY;
        end
    end

    wdlpm_qual #(
        .PINS (PINS),
        .QW   (6)
    ) u_qual (
        .clk    (MCLK),
        .rst    (RST),
        .pins_n (PORTA_N),
        .sel    (wakesel_reg),
        .qual   (cfg.qual),
        .wake   (pin_wake)
    );

    // Low-power state machine
    assign enter_req = IDLE_REQ
        || (wr && AVS_ADDRESS == `WDLPM_OFF_LPCTRL && AVS_BYTEENABLE[0]
            && AVS_WRITEDATA[`WDLPM_LP_ENTER]);

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            WDLPM_RUN: begin
                if (enter_req) begin
                    if (cfg.mode == 2'b00) begin
                        st_next = WDLPM_IDLE;
                    end else if (cfg.mode == 2'b01) begin
                        st_next = WDLPM_STANDBY;
                    end else if (wdck_s) begin
                        st_next = WDLPM_HALT;
                    end
                end
            end
            WDLPM_IDLE: begin
                if (xr_low || cpu_int || pulse_act) begin
                    st_next = WDLPM_RUN;
                end
            end
            WDLPM_STANDBY: begin
                if (xr_low || dbg_low || pin_wake
                    || (pulse_act && !cfg.rst_en)) begin
                    st_next = WDLPM_RUN;
                end
            end
            WDLPM_HALT: begin
                if (xr_low || dbg_low || pin_wake || pulse_act) begin
                    st_next = WDLPM_RUN;
                end
            end
            default: st_next = WDLPM_RUN;
        endcase
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            st_reg <= WDLPM_RUN;
        end else begin
            st_reg <= st_next;
        end
    end

    // Clock gating outputs
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            CPU_CLOCK_IN_EN     <= 1'b1;
            SYSTEM_CLOCK_OUT_EN <= 1'b1;
            OSC_PLL_EN          <= 1'b1;
            PIN_HOLD            <= 1'b0;
        end else begin
            CPU_CLOCK_IN_EN     <= (st_next == WDLPM_RUN)
                                   || (st_next == WDLPM_IDLE);
            SYSTEM_CLOCK_OUT_EN <= (st_next == WDLPM_RUN)
                                   || (st_next == WDLPM_IDLE);
            OSC_PLL_EN          <= (st_next != WDLPM_HALT);
            PIN_HOLD            <= (st_next != WDLPM_RUN);
        end
    end
    assign LP_STATE = st_reg;

    // Registers
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ctrl_reg    <= `WDLPM_CTRL_RST;
            lpctrl_reg  <= `WDLPM_LPCTRL_RST;
            wakesel_reg <= '0;
            mask_reg    <= '0;
        end else if (wr) begin
            case (AVS_ADDRESS)
                `WDLPM_OFF_CTRL: ctrl_reg <= merge(ctrl_reg, AVS_WRITEDATA,
                                                   AVS_BYTEENABLE) & 32'h3;
                `WDLPM_OFF_LPCTRL: lpctrl_reg <= merge(lpctrl_reg,
                    AVS_WRITEDATA, AVS_BYTEENABLE) & 32'h0000_3f03;
                `WDLPM_OFF_WAKESEL: wakesel_reg <= PINS'(merge(
                    32'(wakesel_reg), AVS_WRITEDATA, AVS_BYTEENABLE));
                `WDLPM_OFF_MASK: mask_reg <= AVS_BYTEENABLE[0]
                    ? AVS_WRITEDATA[2:0] : mask_reg;
                default: ;
            endcase
        end
    end

    // Sticky status, cleared by read; a new event wins
    assign ev[`WDLPM_ST_OVF]    = ovf;
    assign ev[`WDLPM_ST_WAKE]   = (st_reg != WDLPM_RUN)
                                  && (st_next == WDLPM_RUN);
    assign ev[`WDLPM_ST_KEYBAD] = key_bad;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            status_reg <= '0;
        end else if (rd && AVS_ADDRESS == `WDLPM_OFF_STATUS) begin
            status_reg <= ev;
        end else begin
            status_reg <= status_reg | ev;
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(status_reg & mask_reg);
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        case (AVS_ADDRESS)
            `WDLPM_OFF_KEY:     rdata_next = {31'h0, key_half_reg};
            `WDLPM_OFF_CTRL:    rdata_next = ctrl_reg;
            `WDLPM_OFF_LPCTRL:  rdata_next = lpctrl_reg;
            `WDLPM_OFF_WAKESEL: rdata_next = 32'(wakesel_reg);
            `WDLPM_OFF_STATUS:  rdata_next = {29'h0, status_reg};
            `WDLPM_OFF_MASK:    rdata_next = {29'h0, mask_reg};
            `WDLPM_OFF_COUNT:   rdata_next = {22'h0, st_reg, cnt_reg};
            default:            rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            AVS_READDATA <= '0;
        end else if (rd) begin
            AVS_READDATA <= rdata_next;
        end
    end
endmodule

// ### wdlpm_props.sv
// Port-level checks of the watchdog and low-power block
module wdlpm_props (
    input wire logic       MCLK,
    input wire logic       RST,
    input wire logic       AVS_READ,
    input wire logic       AVS_WRITE,
    input wire logic       AVS_WAITREQUEST,
    input wire logic       WATCHDOG_RESET_OUT_N,
    input wire logic       WATCHDOG_WAKE_INT_N,
    input wire logic       EXPANDER_INT,
    input wire logic       CPU_CLOCK_IN_EN,
    input wire logic       SYSTEM_CLOCK_OUT_EN,
    input wire logic       OSC_PLL_EN,
    input wire logic       PIN_HOLD,
    input wire logic [1:0] LP_STATE,
    input wire logic       WATCHDOG_CLOCK_OK
);
    logic       pulse;
    logic [9:0] run_reg;
    assign pulse = !WATCHDOG_RESET_OUT_N || !WATCHDOG_WAKE_INT_N;
    // Length of the current watchdog pulse
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            run_reg <= 10'h000;
        end else begin
            run_reg <= pulse ? run_reg + 10'h001 : 10'h000;
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    pulse_len_a: assert property ($fell(pulse) |-> run_reg == 10'h200)
        else $error("pulse not 512 cycles");
    rst_hold_a: assert property ($fell(WATCHDOG_RESET_OUT_N) |->
        (!WATCHDOG_RESET_OUT_N) [*8]) else $error("reset pulse too short");
    idle_clk_a: assert property (!LP_STATE[1] |-> CPU_CLOCK_IN_EN &&
        SYSTEM_CLOCK_OUT_EN && OSC_PLL_EN) else $error("clock off in run");
    stby_clk_a: assert property (LP_STATE == 2'h2 |-> OSC_PLL_EN &&
        !CPU_CLOCK_IN_EN && !SYSTEM_CLOCK_OUT_EN) else $error("standby clk");
    halt_osc_a: assert property (LP_STATE == 2'h3 |-> !OSC_PLL_EN &&
        !CPU_CLOCK_IN_EN) else $error("halt clocks");
    pin_hold_a: assert property (PIN_HOLD == (LP_STATE != 2'h0))
        else $error("pin hold mismatch");
    halt_gate_a: assert property ($changed(LP_STATE) && LP_STATE == 2'h3
        |-> $past(WATCHDOG_CLOCK_OK)) else $error("halt without clock");
    halt_int_a: assert property ($fell(WATCHDOG_WAKE_INT_N) |->
        $past(LP_STATE) != 2'h3) else $error("interrupt form in halt");
    expander_a: assert property (EXPANDER_INT |->
        !WATCHDOG_WAKE_INT_N && !$past(LP_STATE[1]))
        else $error("stray expander");
    bus_wait_a: assert property ($rose(AVS_READ || AVS_WRITE) |->
        AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("wait state");
endmodule
bind wdlpm_top wdlpm_props i_props (
    .MCLK(MCLK), .RST(RST), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .EXPANDER_INT(EXPANDER_INT),
    .WATCHDOG_RESET_OUT_N(WATCHDOG_RESET_OUT_N),
    .WATCHDOG_WAKE_INT_N(WATCHDOG_WAKE_INT_N),
    .CPU_CLOCK_IN_EN(CPU_CLOCK_IN_EN), .OSC_PLL_EN(OSC_PLL_EN),
    .SYSTEM_CLOCK_OUT_EN(SYSTEM_CLOCK_OUT_EN), .PIN_HOLD(PIN_HOLD),
    .LP_STATE(LP_STATE), .WATCHDOG_CLOCK_OK(WATCHDOG_CLOCK_OK)
);

// ### wdlpm_wake.sv
// Wake-source model: holds one active-low line low for a set span
module wdlpm_wake (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       fire,
    input  wire logic [1:0] src,
    input  wire logic [4:0] pin,
    input  wire logic [7:0] len,
    output logic [31:0]     porta_n,
    output logic            ext_reset_n,
    output logic            debug_wake_n,
    output logic            cpu_int_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_reg;
    logic [1:0] src_reg;
    logic [4:0] pin_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            left_reg <= 8'h00;
            src_reg  <= 2'h0;
            pin_reg  <= 5'h00;
        end else if (fire) begin
            left_reg <= len;
            src_reg  <= src;
            pin_reg  <= pin;
        end else if (left_reg != 8'h00) begin
            left_reg <= left_reg - 8'h01;
        end
    end
    // Released lines return to their pulled-up high level
    always_comb begin
        porta_n      = 32'hffff_ffff;
        ext_reset_n  = 1'b1;
        debug_wake_n = 1'b1;
        cpu_int_n    = 1'b1;
        if (left_reg != 8'h00) begin
            case (src_reg)
                2'h0: porta_n[pin_reg] = 1'b0;
                2'h1: ext_reset_n = 1'b0;
                2'h2: debug_wake_n = 1'b0;
                default: cpu_int_n = 1'b0;
            endcase
        end
    end
endmodule

// ### tb_top.sv
// Self-checking bench: watchdog, key, interrupt and low-power modes
`include "wdlpm_defs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
    logic        MCLK, RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, IDLE_REQ;
    logic        LIMP_ACTIVE, WATCHDOG_CLOCK_OK, EXT_RESET_N, DEBUG_WAKE_N;
    logic        CPU_INT_N, WATCHDOG_RESET_OUT_N, WATCHDOG_WAKE_INT_N, IRQ;
    logic        EXPANDER_INT, PIN_HOLD, fire;
    logic [1:0]  LP_STATE, src;
    logic [3:0]  AVS_ADDRESS;
    logic [4:0]  pin;
    logic [7:0]  len;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, PORTA_N, q, c1;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          k;
    logic [1:0]  ex [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
    logic [1:0]  wsrc [4] = '{2'h3, 2'h0, 2'h2, 2'h1};
    wdlpm_top #(.PRESCL(2)) i_dut (
        .MCLK(MCLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(4'hf),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .EXT_RESET_N(EXT_RESET_N),
        .PORTA_N(PORTA_N), .DEBUG_WAKE_N(DEBUG_WAKE_N), .IRQ(IRQ),
        .LIMP_ACTIVE(LIMP_ACTIVE), .WATCHDOG_CLOCK_OK(WATCHDOG_CLOCK_OK),
        .CPU_INT_N(CPU_INT_N), .IDLE_REQ(IDLE_REQ),
        .WATCHDOG_RESET_OUT_N(WATCHDOG_RESET_OUT_N),
        .WATCHDOG_WAKE_INT_N(WATCHDOG_WAKE_INT_N),
        .EXPANDER_INT(EXPANDER_INT), .CPU_CLOCK_IN_EN(),
        .SYSTEM_CLOCK_OUT_EN(), .OSC_PLL_EN(), .PIN_HOLD(PIN_HOLD),
        .LP_STATE(LP_STATE)
    );
    wdlpm_wake i_wake (
        .clk(MCLK), .rst(RST), .fire(fire), .src(src), .pin(pin),
        .len(len), .porta_n(PORTA_N), .ext_reset_n(EXT_RESET_N),
        .debug_wake_n(DEBUG_WAKE_N), .cpu_int_n(CPU_INT_N)
    );
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge MCLK);
        AVS_READ      <= !wr;
        AVS_WRITE     <= wr;
        AVS_ADDRESS   <= a;
        AVS_WRITEDATA <= d;
        do begin
            @(posedge MCLK);
        end while (AVS_WAITREQUEST !== 1'b0);
        q = AVS_READDATA;
        AVS_READ  <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask
    task automatic hold_low(input logic [1:0] s, input logic [7:0] n);
        @(posedge MCLK);
        fire <= 1'b1;
        src  <= s;
        len  <= n;
        @(posedge MCLK);
        fire <= 1'b0;
    endtask
    task automatic enter(input logic [1:0] m);
        bus(1'b1, `WDLPM_OFF_LPCTRL, {18'h0, 6'h04, 6'h00, m});
        if (m[0]) begin
            // Enter through the register's enter bit
            bus(1'b1, `WDLPM_OFF_LPCTRL, {18'h0, 6'h04, 6'h01, m});
        end else begin
            IDLE_REQ <= 1'b1;
            @(posedge MCLK);
            IDLE_REQ <= 1'b0;
        end
    endtask
    task automatic wait_st(input logic [1:0] s, input int lim);
        for (int i = 0; i < lim && LP_STATE !== s; i++) @(negedge MCLK);
    endtask
    task automatic print_verdict();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end
    initial begin
        repeat (20000) @(posedge MCLK);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        {RST, WATCHDOG_CLOCK_OK} = 2'h3;
        {AVS_READ, AVS_WRITE, IDLE_REQ, LIMP_ACTIVE, fire} = 5'h00;
        {AVS_ADDRESS, AVS_WRITEDATA, src, pin, len} = '0;
        repeat (6) @(posedge MCLK);
        RST <= 1'b0;
        bus(1'b0, 4'hf, 32'h0);
        `CHK(q, 32'h0)
        bus(1'b0, `WDLPM_OFF_CTRL, 32'h0);
        `CHK(q, `WDLPM_CTRL_RST)
        bus(1'b1, `WDLPM_OFF_KEY, {24'h0, `WDLPM_KEY_FIRST});
        bus(1'b1, `WDLPM_OFF_KEY, {24'h0, `WDLPM_KEY_SECOND});
        bus(1'b0, `WDLPM_OFF_COUNT, 32'h0);
        `CHK(q[7:0] < 8'h04, 1'b1)
        repeat (20) @(negedge MCLK);
        bus(1'b0, `WDLPM_OFF_COUNT, 32'h0);
        c1 = q;
        bus(1'b1, `WDLPM_OFF_KEY, {24'h0, `WDLPM_KEY_FIRST});
        bus(1'b1, `WDLPM_OFF_KEY, 32'h12);
        bus(1'b1, `WDLPM_OFF_KEY, {24'h0, `WDLPM_KEY_SECOND});
        bus(1'b0, `WDLPM_OFF_COUNT, 32'h0);
        `CHK(q[7:0] > c1[7:0], 1'b1)
        bus(1'b0, `WDLPM_OFF_STATUS, 32'h0);
        `CHK(q[`WDLPM_ST_KEYBAD], 1'b1)
        bus(1'b1, `WDLPM_OFF_CTRL, 32'h2);
        wait (WATCHDOG_RESET_OUT_N === 1'b0);
        @(negedge MCLK);
        `CHK(WATCHDOG_WAKE_INT_N, 1'b1)
        wait (WATCHDOG_RESET_OUT_N === 1'b1);
        bus(1'b0, `WDLPM_OFF_STATUS, 32'h0);
        `CHK(q[2:0], 3'h1)
        bus(1'b1, `WDLPM_OFF_MASK, 32'h1);
        bus(1'b1, `WDLPM_OFF_CTRL, 32'h0);
        wait (WATCHDOG_WAKE_INT_N === 1'b0);
        repeat (2) @(negedge MCLK);
        `CHK({WATCHDOG_RESET_OUT_N, EXPANDER_INT, IRQ}, 3'h7)
        bus(1'b1, `WDLPM_OFF_MASK, 32'h0);
        repeat (2) @(negedge MCLK);
        `CHK(IRQ, 1'b0)
        bus(1'b1, `WDLPM_OFF_MASK, 32'h1);
        bus(1'b0, `WDLPM_OFF_STATUS, 32'h0);
        @(negedge MCLK);
        `CHK(IRQ, 1'b0)
        wait (WATCHDOG_WAKE_INT_N === 1'b1);
        bus(1'b1, `WDLPM_OFF_CTRL, 32'h1);
        k = 0;
        repeat (1200) begin
            @(negedge MCLK);
            if ((WATCHDOG_RESET_OUT_N & WATCHDOG_WAKE_INT_N) !== 1'b1) k++;
        end
        `CHK(k, 0)
        bus(1'b1, `WDLPM_OFF_CTRL, 32'h0);
        LIMP_ACTIVE <= 1'b1;
        repeat (10) @(negedge MCLK);
        bus(1'b0, `WDLPM_OFF_COUNT, 32'h0);
        c1 = q;
        repeat (40) @(negedge MCLK);
        bus(1'b0, `WDLPM_OFF_COUNT, 32'h0);
        `CHK(q[7:0], c1[7:0])
        LIMP_ACTIVE <= 1'b0;
        bus(1'b1, `WDLPM_OFF_CTRL, 32'h1);
        bus(1'b1, `WDLPM_OFF_WAKESEL, 32'h0000_0010);
        for (int m = 0; m < 4; m++) begin
            enter(m[1:0]);
            wait_st(ex[m], 20);
            `CHK({LP_STATE, PIN_HOLD}, {ex[m], 1'b1})
            pin = 5'h05;
            hold_low(2'h0, 8'h1e);
            repeat (40) @(negedge MCLK);
            `CHK(LP_STATE, ex[m])
            pin = 5'h04;
            hold_low(2'h0, 8'h02);
            repeat (40) @(negedge MCLK);
            `CHK(LP_STATE, ex[m])
            hold_low(wsrc[m], 8'h1e);
            wait_st(2'h0, 60);
            `CHK(LP_STATE, 2'h0)
            repeat (40) @(negedge MCLK);
        end
        @(posedge MCLK);
        WATCHDOG_CLOCK_OK <= 1'b0;
        enter(2'h2);
        repeat (20) @(negedge MCLK);
        `CHK(LP_STATE, 2'h0)
        bus(1'b1, `WDLPM_OFF_CTRL, 32'h0);
        WATCHDOG_CLOCK_OK <= 1'b1;
        enter(2'h1);
        wait_st(2'h1, 20);
        wait_st(2'h0, 1200);
        `CHK({LP_STATE, WATCHDOG_WAKE_INT_N}, 3'h0)
        print_verdict();
    end
endmodule
